// file: verilog/pio_pkg.sv
// How it works
// RL1: Two select lines pick data A, B, C or control
// RL2: Strobes count only while chip select is low; acknowledge reads and the joint-strobe reset count without it
// RL3: Data bus driven only during our reads
// RL4: High chain input means no higher-priority activity
// RL5: Chain output high only when idle here and above us
// RL6: Interrupt line pulled low while request pending
// RL7: Host holds acknowledge stable, synchronous to clock
// RL8: Acknowledge read drives vector only if we win
// RL9: Read and write low together resets the part
// RL10: One peripheral clock runs all control logic
// RL11: Direction bit one is input, zero output
// RL12: Polarity bit one inverts pin-to-register path
// RL13: Third port bit-addressable, no pattern logic
// RL14: Unclaimed third-port lines are plain bit lines
// RL15: Ports A and B can link as sixteen bits
// RL16: Each status register holds pending, service, enable
// RL17: Unused capability registers have no effect
// RL18: Third-port upper write bits protect lower bits
// RL19: A/B read driven outputs; third port reads pins
// RL20: Writes to inputs ignored except catcher clear
// RL21: Strobes and reset condition sampled on clock
package pio_pkg;
    // Port widths
    localparam int PORT_AB_W = 8;
    localparam int PORT_C_W = 4;
    localparam int LINE_N = 2 * PORT_AB_W + PORT_C_W;
    // Register select codes
    localparam logic [1:0] SEL_DATA_C = 2'h0;
    localparam logic [1:0] SEL_DATA_B = 2'h1;
    localparam logic [1:0] SEL_DATA_A = 2'h2;
    localparam logic [1:0] SEL_CTL = 2'h3;
    // Control pointers: global registers
    localparam logic [7:0] PTR_MASTER = 8'h00;
    localparam logic [7:0] PTR_VECTOR = 8'h01;
    // Control pointers: bits 7:3 name the port, bits 2:0 the register in it
    localparam logic [4:0] PTR_PORT_A = 5'h02;
    localparam logic [4:0] PTR_PORT_B = 5'h03;
    localparam logic [4:0] PTR_PORT_C = 5'h04;
    localparam logic [2:0] OFS_POL = 3'h0;
    localparam logic [2:0] OFS_DIR = 3'h1;
    localparam logic [2:0] OFS_SPC = 3'h2;
    localparam logic [2:0] OFS_CS = 3'h3;
    // Master control fields
    localparam int MC_MIE_BIT = 0;
    localparam int MC_LINK_BIT = 1;
    // Command and status fields
    localparam int CS_IUS_BIT = 7;
    localparam int CS_IE_BIT = 6;
    localparam int CS_IP_BIT = 5;
    localparam int CS_CMD_LSB = 5;
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_CLR_IP_IUS = 3'h1;
    localparam logic [2:0] CMD_SET_IUS = 3'h2;
    localparam logic [2:0] CMD_CLR_IUS = 3'h3;
    localparam logic [2:0] CMD_SET_IP = 3'h4;
    localparam logic [2:0] CMD_CLR_IP = 3'h5;
    localparam logic [2:0] CMD_SET_IE = 3'h6;
    localparam logic [2:0] CMD_CLR_IE = 3'h7;
    // Reset values
    localparam logic [7:0] RST_MASTER = 8'h00;
    localparam logic [7:0] RST_VECTOR = 8'h00;
    localparam logic [7:0] RST_POL = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_SPC = 8'h00;
    // Control access sequence
    typedef enum logic {CTL_PTR, CTL_DATA} pio_ctl_type;
endpackage

// file: verilog/pio_line_cell.sv
`timescale 1ns/1ps
`default_nettype none
module pio_line_cell (
    // Clock and clear
    input wire logic clk,
    input wire logic clear,
    // Per-line configuration
    input wire logic dir,
    input wire logic pol,
    input wire logic spc,
    input wire logic pin_read,
    // Host write
    input wire logic wr_en,
    input wire logic wr_bit,
    // Pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    // Read and event
    output logic rd_bit,
    output logic catch_set
);
    logic out_r;
    logic catch_r;
    logic in_val;
    logic catch_on;

    // Register-side view of the pin
    assign in_val = pin_in ^ pol; // RL12
    // Catcher only meaningful on inputs; on outputs the same bit means open drain
    assign catch_on = dir & spc; // RL17
    assign catch_set = catch_on & in_val & ~catch_r;

    // Output latch ignores writes while the line is an input
    always_ff @(posedge clk)
    begin
        if (clear)
            out_r <= 1'b0;
        else if (wr_en && !dir) // RL11 RL20
            out_r <= wr_bit;
    end

    // Ones catcher: a new one wins over a clearing write of zero
    always_ff @(posedge clk)
    begin
        if (clear || !catch_on)
            catch_r <= 1'b0;
        else if (in_val)
            catch_r <= 1'b1;
        else if (wr_en && !wr_bit) // RL20
            catch_r <= 1'b0;
    end

    // Read value
    always_comb
    begin
        if (dir)
            rd_bit = catch_on ? catch_r : in_val;
        else
            rd_bit = pin_read ? in_val : out_r; // RL19
    end

    // Pin drive, open drain when selected on an output
    always_comb
    begin
        if (spc)
        begin
            pin_out = 1'b0;
            pin_oe_n = dir | (out_r ^ pol); // RL11 RL12
        end
        else
        begin
            pin_out = out_r ^ pol;
            pin_oe_n = dir;
        end
    end
endmodule // pio_line_cell
`default_nettype wire

// file: verilog/pio_host_if.sv
`timescale 1ns/1ps
`default_nettype none
module pio_host_if
    import pio_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Host bus
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [1:0] register_select,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_n,
    // Interrupt chain
    input wire logic chain_enable_in,
    input wire logic vector_ack_in_n,
    output logic chain_enable_out,
    input wire logic int_req_n_in,
    output logic int_req_n_out,
    output logic int_req_n_oe_n,
    // Port A lines
    input wire logic [PORT_AB_W-1:0] port_a_lines_in,
    output logic [PORT_AB_W-1:0] port_a_lines_out,
    output logic [PORT_AB_W-1:0] port_a_lines_oe_n,
    // Port B lines
    input wire logic [PORT_AB_W-1:0] port_b_lines_in,
    output logic [PORT_AB_W-1:0] port_b_lines_out,
    output logic [PORT_AB_W-1:0] port_b_lines_oe_n,
    // Port C lines
    input wire logic [PORT_C_W-1:0] port_c_lines_in,
    output logic [PORT_C_W-1:0] port_c_lines_out,
    output logic [PORT_C_W-1:0] port_c_lines_oe_n
);
    // Internal reset and strobe decode
    logic strobe_rst;
    logic clear;
    logic rd_act;
    logic wr_act;
    logic ack_rd;
    logic rd_prev_r;
    logic wr_prev_r;
    logic ack_prev_r;
    logic rd_take;
    logic wr_take;
    logic ack_take;
    // Control path
    pio_ctl_type ctl_state_r;
    logic [7:0] ptr_r;
    logic ctl_wr;
    logic [4:0] ptr_port;
    logic [2:0] ptr_ofs;
    // Configuration
    logic [7:0] master_r;
    logic [7:0] vector_r;
    logic [7:0] line_inversion_select [3];
    logic [7:0] line_direction_select [3];
    logic [7:0] special_r [3];
    // Interrupt flags for ports A and B
    logic [1:0] ip_r;
    logic [1:0] ius_r;
    logic [1:0] ie_r;
    logic [1:0] ip_set;
    logic [1:0] req;
    logic requesting;
    logic any_ius;
    logic ack_win;
    logic ack_src;
    logic ack_drive_r;
    // Link shadows
    logic linked;
    logic [7:0] link_b_wr_r;
    logic [7:0] link_a_rd_r;
    // Line arrays, A in bits 7:0, B in 15:8, C in 19:16
    logic [LINE_N-1:0] dir_all;
    logic [LINE_N-1:0] pol_all;
    logic [LINE_N-1:0] spc_all;
    logic [LINE_N-1:0] pin_in_all;
    logic [LINE_N-1:0] pin_out_all;
    logic [LINE_N-1:0] pin_oe_n_all;
    logic [LINE_N-1:0] wr_en_all;
    logic [LINE_N-1:0] wr_bit_all;
    logic [LINE_N-1:0] rd_all;
    logic [LINE_N-1:0] catch_all;
    logic wr_a;
    logic wr_b;
    logic wr_c;
    logic [7:0] rd_mux;

    // Both strobes low is a reset, caught on the clock like every other strobe
    assign strobe_rst = ~rd_n & ~wr_n; // RL9 RL21
    assign clear = ~rstn | strobe_rst; // RL9
    assign rd_act = ~cs_n & ~rd_n & wr_n & vector_ack_in_n; // RL2
    assign wr_act = ~cs_n & ~wr_n & rd_n & vector_ack_in_n; // RL2
    // Acknowledge reads need no chip select; host keeps the acknowledge steady
    assign ack_rd = ~vector_ack_in_n & ~rd_n & wr_n; // RL8
    assign rd_take = rd_act & ~rd_prev_r;
    assign wr_take = wr_act & ~wr_prev_r;
    assign ack_take = ack_rd & ~ack_prev_r;

    // Strobe history for edge detection
    always_ff @(posedge clk)
    begin
        if (clear)
        begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            ack_prev_r <= 1'b0;
        end
        else
        begin
            rd_prev_r <= rd_act; // RL21 RL10
            wr_prev_r <= wr_act; // RL21
            ack_prev_r <= ack_rd; // RL21
        end
    end

    // Control path: a write loads the pointer, the next access uses it
    assign ptr_port = ptr_r[7:3];
    assign ptr_ofs = ptr_r[2:0];
    assign ctl_wr = wr_take && register_select == SEL_CTL && ctl_state_r == CTL_DATA; // RL1

    always_ff @(posedge clk)
    begin
        if (clear)
        begin
            ctl_state_r <= CTL_PTR;
            ptr_r <= PTR_MASTER;
        end
        else if (register_select == SEL_CTL && (wr_take || rd_take))
        begin
            case (ctl_state_r)
                CTL_PTR:
                begin
                    if (wr_take)
                    begin
                        ptr_r <= host_data_in;
                        ctl_state_r <= CTL_DATA;
                    end
                end
                CTL_DATA:
                    ctl_state_r <= CTL_PTR;
                default:
                    ctl_state_r <= CTL_PTR;
            endcase
        end
    end

    // Global registers
    always_ff @(posedge clk)
    begin
        if (clear)
        begin
            master_r <= RST_MASTER;
            vector_r <= RST_VECTOR;
        end
        else if (ctl_wr && ptr_r == PTR_MASTER)
            master_r <= host_data_in;
        else if (ctl_wr && ptr_r == PTR_VECTOR)
            vector_r <= host_data_in;
    end
    assign linked = master_r[MC_LINK_BIT];

    // Per-port path registers
    always_ff @(posedge clk)
    begin
        for (int p = 0; p < 3; p++)
        begin
            if (clear)
            begin
                line_inversion_select[p] <= RST_POL;
                line_direction_select[p] <= RST_DIR;
                special_r[p] <= RST_SPC;
            end
            else if (ctl_wr && ptr_port == PTR_PORT_A + 5'(p))
            begin
                if (ptr_ofs == OFS_POL)
                    line_inversion_select[p] <= host_data_in; // RL12
                if (ptr_ofs == OFS_DIR)
                    line_direction_select[p] <= host_data_in; // RL11
                if (ptr_ofs == OFS_SPC)
                    special_r[p] <= host_data_in;
            end
        end
    end

    // Pending, in-service and enable flags; hardware set wins over a clear
    always_ff @(posedge clk)
    begin
        for (int k = 0; k < 2; k++)
        begin
            if (clear)
            begin
                ip_r[k] <= 1'b0;
                ius_r[k] <= 1'b0;
                ie_r[k] <= 1'b0;
            end
            else
            begin
                ip_r[k] <= ip_r[k] | ip_set[k];
                if (ack_take && ack_win && ack_src == 1'(k)) // RL8
                    ius_r[k] <= 1'b1;
                if (ctl_wr && ptr_port == PTR_PORT_A + 5'(k) && ptr_ofs == OFS_CS) // RL16
                begin
                    case (host_data_in[CS_CMD_LSB +: 3])
                        CMD_CLR_IP_IUS:
                        begin
                            ip_r[k] <= ip_set[k];
                            ius_r[k] <= ack_take && ack_win && ack_src == 1'(k);
                        end
                        CMD_SET_IUS:
                            ius_r[k] <= 1'b1;
                        CMD_CLR_IUS:
                            ius_r[k] <= ack_take && ack_win && ack_src == 1'(k);
                        CMD_SET_IP:
                            ip_r[k] <= 1'b1;
                        CMD_CLR_IP:
                            ip_r[k] <= ip_set[k];
                        CMD_SET_IE:
                            ie_r[k] <= 1'b1;
                        CMD_CLR_IE:
                            ie_r[k] <= 1'b0;
                        default:
                            ie_r[k] <= ie_r[k];
                    endcase
                end
            end
        end
    end

    // A newly caught one on port A or B raises that port's pending flag
    assign ip_set[0] = |catch_all[PORT_AB_W-1:0];
    assign ip_set[1] = |catch_all[2*PORT_AB_W-1:PORT_AB_W];

    // Interrupt request and chain; port A outranks port B
    assign req = ip_r & ie_r & ~ius_r;
    assign any_ius = |ius_r;
    assign requesting = master_r[MC_MIE_BIT] & (|req) & ~any_ius;
    assign ack_src = ~req[0];
    assign ack_win = chain_enable_in & requesting; // RL4 RL8
    assign chain_enable_out = chain_enable_in & ~any_ius
        & ~(~vector_ack_in_n & requesting); // RL5
    assign int_req_n_out = 1'b0;
    // Pulled low only while a request stands; the line is shared with others
    assign int_req_n_oe_n = ~requesting; // RL6

    // Link: B write is held and lands with A; B read freezes A for the next read
    always_ff @(posedge clk)
    begin
        if (clear)
        begin
            link_b_wr_r <= 8'h00;
            link_a_rd_r <= 8'h00;
        end
        else
        begin
            if (wr_take && register_select == SEL_DATA_B) // RL15
                link_b_wr_r <= host_data_in;
            if (rd_take && register_select == SEL_DATA_B) // RL15
                link_a_rd_r <= rd_all[PORT_AB_W-1:0];
        end
    end

    // Data register writes
    assign wr_a = wr_take && register_select == SEL_DATA_A; // RL1
    assign wr_b = wr_take && register_select == SEL_DATA_B && !linked; // RL15
    assign wr_c = wr_take && register_select == SEL_DATA_C; // RL13

    // Flatten configuration and write enables per line
    always_comb
    begin
        dir_all = {line_direction_select[2][PORT_C_W-1:0], line_direction_select[1],
            line_direction_select[0]};
        pol_all = {line_inversion_select[2][PORT_C_W-1:0], line_inversion_select[1],
            line_inversion_select[0]};
        spc_all = {special_r[2][PORT_C_W-1:0], special_r[1], special_r[0]};
        pin_in_all = {port_c_lines_in, port_b_lines_in, port_a_lines_in};
        // Upper nibble of a third-port write masks the lower nibble
        wr_en_all = {{PORT_C_W{wr_c}} & ~host_data_in[7:4], {PORT_AB_W{wr_b | (wr_a & linked)}},
            {PORT_AB_W{wr_a}}}; // RL18 RL13
        wr_bit_all = {host_data_in[PORT_C_W-1:0], linked ? link_b_wr_r : host_data_in,
            host_data_in};
    end

    // One cell per line; third-port lines are all plain bit lines here
    genvar gi;
    generate
        for (gi = 0; gi < LINE_N; gi++)
        begin : g_line
            pio_line_cell u_cell (
                .clk(clk),
                .clear(clear),
                .dir(dir_all[gi]),
                .pol(pol_all[gi]),
                .spc(spc_all[gi]),
                .pin_read(gi >= 2 * PORT_AB_W), // RL19 RL14
                .wr_en(wr_en_all[gi]),
                .wr_bit(wr_bit_all[gi]),
                .pin_in(pin_in_all[gi]),
                .pin_out(pin_out_all[gi]),
                .pin_oe_n(pin_oe_n_all[gi]),
                .rd_bit(rd_all[gi]),
                .catch_set(catch_all[gi])
            );
        end
    endgenerate

    // Pins
    assign port_a_lines_out = pin_out_all[PORT_AB_W-1:0];
    assign port_a_lines_oe_n = pin_oe_n_all[PORT_AB_W-1:0];
    assign port_b_lines_out = pin_out_all[2*PORT_AB_W-1:PORT_AB_W];
    assign port_b_lines_oe_n = pin_oe_n_all[2*PORT_AB_W-1:PORT_AB_W];
    assign port_c_lines_out = pin_out_all[LINE_N-1:2*PORT_AB_W];
    assign port_c_lines_oe_n = pin_oe_n_all[LINE_N-1:2*PORT_AB_W];

    // Read selection; unmapped pointers read as zero
    always_comb
    begin
        rd_mux = 8'h00;
        case (register_select)
            SEL_DATA_A:
                rd_mux = linked ? link_a_rd_r : rd_all[PORT_AB_W-1:0]; // RL15
            SEL_DATA_B:
                rd_mux = rd_all[2*PORT_AB_W-1:PORT_AB_W];
            SEL_DATA_C:
                rd_mux = {4'h0, rd_all[LINE_N-1:2*PORT_AB_W]}; // RL19
            default:
            begin
                if (ptr_r == PTR_MASTER)
                    rd_mux = master_r;
                else if (ptr_r == PTR_VECTOR)
                    rd_mux = vector_r;
                else
                begin
                    for (int p = 0; p < 3; p++)
                    begin
                        if (ptr_port == PTR_PORT_A + 5'(p))
                        begin
                            if (ptr_ofs == OFS_POL)
                                rd_mux = line_inversion_select[p];
                            if (ptr_ofs == OFS_DIR)
                                rd_mux = line_direction_select[p];
                            if (ptr_ofs == OFS_SPC)
                                rd_mux = special_r[p];
                            if (ptr_ofs == OFS_CS && p < 2)
                            begin
                                rd_mux[CS_IUS_BIT] = ius_r[p];
                                rd_mux[CS_IE_BIT] = ie_r[p];
                                rd_mux[CS_IP_BIT] = ip_r[p];
                            end
                        end
                    end
                end
            end
        endcase
    end

    // Read data latched at the start of a read or a won acknowledge
    always_ff @(posedge clk)
    begin
        if (clear)
            host_data_out <= 8'h00;
        else if (rd_take) // RL1
            host_data_out <= rd_mux;
        else if (ack_take && ack_win) // RL8
            host_data_out <= {vector_r[7:1], ack_src};
    end

    // Bus drive only during our own reads
    always_ff @(posedge clk)
    begin
        if (clear)
        begin
            ack_drive_r <= 1'b0;
            host_data_oe_n <= 1'b1;
        end
        else
        begin
            if (!ack_rd)
                ack_drive_r <= 1'b0;
            else if (ack_take)
                ack_drive_r <= ack_win;
            host_data_oe_n <= ~(rd_act | (ack_rd & (ack_take ? ack_win : ack_drive_r))); // RL3
        end
    end
endmodule // pio_host_if
`default_nettype wire

// file: testbench/pio_host_if_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pio_host_if_sva
    import pio_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Host side
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic host_data_oe_n,
    // Chain and lines
    input wire logic chain_enable_in,
    input wire logic vector_ack_in_n,
    input wire logic chain_enable_out,
    input wire logic int_req_n_out,
    input wire logic int_req_n_oe_n,
    input wire logic [PORT_AB_W-1:0] port_a_lines_oe_n,
    input wire logic [PORT_C_W-1:0] port_c_lines_oe_n
);
    // All checks share the one peripheral clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    chain_block_a: assert property (!chain_enable_in |-> !chain_enable_out)
        else $error("chain out high while chain in low");
    ack_block_a: assert property ((!vector_ack_in_n && !int_req_n_oe_n) |-> !chain_enable_out)
        else $error("chain out high during acknowledge while requesting");
    irq_drive_a: assert property (!int_req_n_oe_n |-> (int_req_n_out == 1'b0))
        else $error("request line driven high");
    bus_quiet_a: assert property ((rd_n && $past(rd_n)) |-> host_data_oe_n)
        else $error("data bus driven without a read");
    chip_off_a: assert property ((cs_n && $past(cs_n) && vector_ack_in_n
        && $past(vector_ack_in_n)) |-> host_data_oe_n)
        else $error("data bus driven while deselected");
    read_drive_a: assert property ((!cs_n && !rd_n && wr_n && vector_ack_in_n)[*3]
        |-> !host_data_oe_n)
        else $error("held read not answered on the bus");
    strobe_reset_a: assert property ((!rd_n && !wr_n) |=> (host_data_oe_n && int_req_n_oe_n
        && (&port_a_lines_oe_n) && (&port_c_lines_oe_n)))
        else $error("joint strobes did not reset");
    lost_ack_a: assert property ((!chain_enable_in && !vector_ack_in_n)[*3]
        |-> host_data_oe_n)
        else $error("vector driven without chain priority");
    // Line direction only moves after a host write or a reset
    dir_change_a: assert property ((!$stable(port_a_lines_oe_n) || !$stable(port_c_lines_oe_n))
        |-> (!$past(wr_n) || !$past(rstn)))
        else $error("line direction changed without a write");
endmodule // pio_host_if_sva
`default_nettype wire

// file: testbench/pio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pio_pin_model
    import pio_pkg::*;
#(
    parameter logic [PORT_AB_W-1:0] EXT_A = 8'hA3,
    parameter logic [PORT_AB_W-1:0] EXT_B = 8'h5C,
    parameter logic [PORT_C_W-1:0] EXT_C = 4'h9
)
(
    // Device drive
    input wire logic [PORT_AB_W-1:0] port_a_lines_out,
    input wire logic [PORT_AB_W-1:0] port_a_lines_oe_n,
    input wire logic [PORT_AB_W-1:0] port_b_lines_out,
    input wire logic [PORT_AB_W-1:0] port_b_lines_oe_n,
    input wire logic [PORT_C_W-1:0] port_c_lines_out,
    input wire logic [PORT_C_W-1:0] port_c_lines_oe_n,
    input wire logic int_req_n_out,
    input wire logic int_req_n_oe_n,
    // Resolved wire levels
    output logic [PORT_AB_W-1:0] port_a_lines_in,
    output logic [PORT_AB_W-1:0] port_b_lines_in,
    output logic [PORT_C_W-1:0] port_c_lines_in,
    output logic int_req_n_in
);
    // A released line shows what the outside device drives on it
    assign port_a_lines_in = (port_a_lines_out & ~port_a_lines_oe_n) | (EXT_A & port_a_lines_oe_n);
    assign port_b_lines_in = (port_b_lines_out & ~port_b_lines_oe_n) | (EXT_B & port_b_lines_oe_n);
    assign port_c_lines_in = (port_c_lines_out & ~port_c_lines_oe_n) | (EXT_C & port_c_lines_oe_n);
    // Request wire has a pull-up, so a release reads high
    assign int_req_n_in = int_req_n_oe_n | int_req_n_out;
endmodule // pio_pin_model
`default_nettype wire

// file: testbench/pio_host_if_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pio_host_if_tb
    import pio_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic [1:0] register_select = 2'h0;
    logic [7:0] host_data_in = 8'h00;
    logic chain_enable_in = 1'b1;
    logic vector_ack_in_n = 1'b1;
    logic [7:0] host_data_out;
    logic host_data_oe_n, chain_enable_out, int_req_n_in, int_req_n_out, int_req_n_oe_n;
    logic [PORT_AB_W-1:0] port_a_lines_in, port_a_lines_out, port_a_lines_oe_n;
    logic [PORT_AB_W-1:0] port_b_lines_in, port_b_lines_out, port_b_lines_oe_n;
    logic [PORT_C_W-1:0] port_c_lines_in, port_c_lines_out, port_c_lines_oe_n;
    logic [7:0] rd_data;
    logic rd_oe_n;
    int n_mismatch = 0;
    int comparisons = 0;

    // 125 MHz peripheral clock
    always #4 clk = ~clk;

    pio_host_if u_dut (
        .clk, .rstn, .cs_n, .rd_n, .wr_n, .register_select, .host_data_in, .host_data_out,
        .host_data_oe_n, .chain_enable_in, .vector_ack_in_n, .chain_enable_out, .int_req_n_in,
        .int_req_n_out, .int_req_n_oe_n, .port_a_lines_in, .port_a_lines_out,
        .port_a_lines_oe_n, .port_b_lines_in, .port_b_lines_out, .port_b_lines_oe_n,
        .port_c_lines_in, .port_c_lines_out, .port_c_lines_oe_n
    );

    pio_pin_model u_pins (
        .port_a_lines_out, .port_a_lines_oe_n, .port_b_lines_out, .port_b_lines_oe_n,
        .port_c_lines_out, .port_c_lines_oe_n, .int_req_n_out, .int_req_n_oe_n,
        .port_a_lines_in, .port_b_lines_in, .port_c_lines_in, .int_req_n_in
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One host access, held three edges; strobes are edge-taken, so one idle cycle follows
    task automatic acc(input logic [1:0] sel, input logic wr, input logic [7:0] d,
                       input logic csn = 1'b0, input logic ackn = 1'b1);
        @(negedge clk);
        cs_n = csn;
        vector_ack_in_n = ackn;
        register_select = sel;
        host_data_in = d;
        if (wr)
            wr_n = 1'b0;
        else
            rd_n = 1'b0;
        repeat (3) @(negedge clk);
        rd_data = host_data_out;
        rd_oe_n = host_data_oe_n;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        vector_ack_in_n = 1'b1;
    endtask

    // Control path: pointer write, then the register access
    task automatic ctl_wr(input logic [7:0] ptr, input logic [7:0] d);
        acc(SEL_CTL, 1'b1, ptr);
        acc(SEL_CTL, 1'b1, d);
    endtask

    task automatic ctl_rd(input logic [7:0] ptr);
        acc(SEL_CTL, 1'b1, ptr);
        acc(SEL_CTL, 1'b0, 8'h00);
    endtask

    // Watchdog: the sequence needs well under 1000 cycles
    initial
    begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        // Reset direction is all inputs
        ctl_rd({PTR_PORT_A, OFS_DIR});
        check("dir_a reset", rd_data, RST_DIR);
        check("oe_a reset", port_a_lines_oe_n, 8'hFF);
        // Low nibble outputs, bit 0 inverted; ones written to inputs must not stick
        ctl_wr({PTR_PORT_A, OFS_DIR}, 8'hF0);
        ctl_wr({PTR_PORT_A, OFS_POL}, 8'h01);
        acc(SEL_DATA_A, 1'b1, 8'hF5);
        check("oe_a", port_a_lines_oe_n, 8'hF0);
        check("out_a", {4'h0, port_a_lines_out[3:0]}, 8'h04);
        acc(SEL_DATA_A, 1'b0, 8'h00);
        check("read_a", rd_data, 8'hA5);
        acc(SEL_DATA_B, 1'b0, 8'h00);
        check("read_b", rd_data, 8'h5C);
        // Port C masked writes, pin readback and a deselected write
        ctl_wr({PTR_PORT_C, OFS_DIR}, 8'h00);
        acc(SEL_DATA_C, 1'b1, 8'h0F);
        check("out_c set", {4'h0, port_c_lines_out}, 8'h0F);
        acc(SEL_DATA_C, 1'b1, 8'h50);
        check("out_c masked", {4'h0, port_c_lines_out}, 8'h05);
        acc(SEL_DATA_C, 1'b1, 8'h00, 1'b1);
        check("out_c no cs", {4'h0, port_c_lines_out}, 8'h05);
        acc(SEL_DATA_C, 1'b0, 8'h00);
        check("read_c", rd_data & 8'h0F, 8'h05);
        // Both strobes low together resets the part
        @(negedge clk);
        rd_n = 1'b0;
        wr_n = 1'b0;
        @(negedge clk);
        rd_n = 1'b1;
        wr_n = 1'b1;
        @(negedge clk);
        check("oe_c strobe reset", {4'h0, port_c_lines_oe_n}, 8'h0F);
        check("oe_a strobe reset", port_a_lines_oe_n, 8'hFF);
        // A caught one on port B raises its pending flag
        ctl_wr({PTR_PORT_B, OFS_SPC}, 8'h04);
        ctl_rd({PTR_PORT_B, OFS_CS});
        check("catch ip_b", rd_data & 8'hE0, 8'h20);
        // Port A interrupt: enable, vector, set enable then pending by command
        ctl_wr(PTR_MASTER, 8'h01);
        ctl_wr(PTR_VECTOR, 8'h40);
        ctl_wr({PTR_PORT_A, OFS_CS}, 8'hC0);
        ctl_wr({PTR_PORT_A, OFS_CS}, 8'h80);
        check("req line", {7'h0, int_req_n_oe_n}, 8'h00);
        check("chain out idle", {7'h0, chain_enable_out}, 8'h01);
        // Acknowledge with a higher device active: no vector
        chain_enable_in = 1'b0;
        acc(SEL_CTL, 1'b0, 8'h00, 1'b1, 1'b0);
        check("lost ack oe", {7'h0, rd_oe_n}, 8'h01);
        chain_enable_in = 1'b1;
        acc(SEL_CTL, 1'b0, 8'h00, 1'b1, 1'b0);
        check("ack vector", rd_data, 8'h40);
        check("ack oe", {7'h0, rd_oe_n}, 8'h00);
        check("req after ack", {7'h0, int_req_n_oe_n}, 8'h01);
        check("chain in service", {7'h0, chain_enable_out}, 8'h00);
        ctl_rd({PTR_PORT_A, OFS_CS});
        check("status", rd_data & 8'hE0, 8'hE0);
        ctl_wr({PTR_PORT_A, OFS_CS}, 8'h20);
        ctl_rd({PTR_PORT_A, OFS_CS});
        check("status cleared", rd_data & 8'hE0, 8'h40);
        check("chain released", {7'h0, chain_enable_out}, 8'h01);
        report_and_stop();
    end
endmodule // pio_host_if_tb

bind pio_host_if pio_host_if_sva u_sva (
    .clk, .rstn, .cs_n, .rd_n, .wr_n, .host_data_oe_n, .chain_enable_in, .vector_ack_in_n,
    .chain_enable_out, .int_req_n_out, .int_req_n_oe_n, .port_a_lines_oe_n, .port_c_lines_oe_n
);
`default_nettype wire
